// ==== hdl/irq_source_pkg.sv ====
// constants, types and register map of the external interrupt source logic
`default_nettype none
package irq_source_pkg;

  localparam int          DATA_W           = 8;
  localparam int          ADDR_W           = 4;
  localparam int          NUM_EXT          = 8;
  localparam int          NUM_KEY          = 16;
  localparam int          NUM_WAKE         = 8;
  localparam int          VEC_W            = 8;
  localparam int          VADDR_W          = 24;

  // register offsets, one byte register per address
  localparam logic [3:0]  OFS_SYSCTL       = 4'h0;
  localparam logic [3:0]  OFS_SENSE_HI     = 4'h1;
  localparam logic [3:0]  OFS_SENSE_LO     = 4'h2;
  localparam logic [3:0]  OFS_ENABLE       = 4'h3;
  localparam logic [3:0]  OFS_FLAG         = 4'h4;
  localparam logic [3:0]  OFS_LEVEL        = 4'h5;
  localparam logic [3:0]  OFS_KEYMASK_HI   = 4'h6;
  localparam logic [3:0]  OFS_KEYMASK_LO   = 4'h7;
  localparam logic [3:0]  OFS_WAKEMASK     = 4'h8;
  localparam logic [3:0]  OFS_STATUS       = 4'h9;

  // field positions
  localparam int          SYS_NMI_EDGE_BIT = 3;
  localparam int          LVL_REQ0_BIT     = 7;
  localparam int          LVL_REQ1_BIT     = 6;
  localparam int          LVL_REQ2_3_BIT   = 5;
  localparam int          LVL_REQ4_5_BIT   = 4;
  localparam int          LVL_REQ6_7_BIT   = 3;
  localparam int          KEY_MASK6_BIT    = 6;

  // reset values
  localparam logic [7:0]  RST_SYSCTL       = 8'h00;
  localparam logic [15:0] RST_SENSE        = 16'h0000;
  localparam logic [7:0]  RST_ENABLE       = 8'h00;
  localparam logic [7:0]  RST_LEVEL        = 8'h00;
  localparam logic [15:0] RST_KEYMASK      = 16'hFFBF;
  localparam logic [7:0]  RST_WAKEMASK     = 8'hFF;

  // vector numbers
  localparam logic [7:0]  VEC_NMI          = 8'h07;
  localparam logic [7:0]  VEC_EXT_BASE     = 8'h10;

  // sources able to end software standby: 7, 6, 2, 1, 0
  localparam logic [7:0]  WAKE_CAPABLE     = 8'hC7;

  typedef enum logic [1:0] {
    SENSE_LOW  = 2'h0,
    SENSE_FALL = 2'h1,
    SENSE_RISE = 2'h2,
    SENSE_BOTH = 2'h3
  } sense_t;

  // cpu side mask state
  typedef struct packed {
    logic ctrl_mode1;   // interrupt control mode 1 when set
    logic int_mask;     // cpu interrupt mask bit
    logic user_mask;    // user mask bit, mode 1 only
    logic advanced;     // advanced address mode
  } cpu_state_t;

  // request to the cpu
  typedef struct packed {
    logic               valid;
    logic               nmi;
    logic [VEC_W-1:0]   vector;
    logic [VADDR_W-1:0] vaddr;
  } cpu_request_t;

endpackage : irq_source_pkg
`default_nettype wire

// ==== hdl/ext_irq_source.sv ====
// external interrupt source logic: sensing, flags, masking, priority, vector
`default_nettype none

// Notes on behaviour
// R1: nmi always highest, never masked
// R2: control bit picks nmi rising or falling edge
// R3: four sense modes per external request
// R4: each external request has own vector
// R5: enable bit forwards request to cpu
// R6: flag sets even when request disabled
// R7: detection ignores pin direction setting
// R8: high keys, wakeups feed 7; low keys 6
// R9: request-7 pin ignored if any high key mask or wakeup mask clear
// R10: software clears key mask 6 for pin 6
// R11: mask bit 0 enables, 1 blocks input
// R12: key and wakeup share request 6/7 settings
// R13: software picks low or falling sense then
// R14: nmi and 7,6,2,1,0 wake from standby
// R15: peripheral request needs flag and enable
// R16: transfer-controller start ignores cpu masks
// R17: lower vector wins within same level
// R18: level 1 served before level 0
// R19: nmi vector 7, requests 16 to 23
// R20: vector address twice or four times number
// R21: level bits 7,6,5,5,4,4,3,3 for requests
// R22: flags clear by writing 0, 1 ignored
// R23: clear needs prior read as 1
// R24: handling clears edge flag, level if pin high
// R25: enable bits active high, reset 0
// R26: present highest pending request with vector
module ext_irq_source #(
  parameter int NUM_PERIPH = 4
) (
  input  wire logic                                core_clk,
  input  wire logic                                rstn,
  // register port
  input  wire logic [irq_source_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [irq_source_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                                reg_write,
  input  wire logic                                reg_read,
  output logic      [irq_source_pkg::DATA_W-1:0]   reg_rdata,
  // pins, all active low
  input  wire logic                                nonmask_pin,
  input  wire logic [irq_source_pkg::NUM_EXT-1:0]  external_request_pins,
  input  wire logic [irq_source_pkg::NUM_KEY-1:0]  key_sense_inputs,
  input  wire logic [irq_source_pkg::NUM_WAKE-1:0] wakeup_event_inputs,
  // cpu side
  input  wire irq_source_pkg::cpu_state_t          cpu_state,
  input  wire logic                                handling_start,
  input  wire logic [irq_source_pkg::VEC_W-1:0]    handling_vector,
  input  wire logic                                standby,
  output irq_source_pkg::cpu_request_t             cpu_request,
  output logic                                     wake_request,
  // on-chip peripheral requests
  input  wire logic [NUM_PERIPH-1:0]               periph_flag,
  input  wire logic [NUM_PERIPH-1:0]               periph_enable,
  input  wire logic [NUM_PERIPH-1:0]               periph_to_transfer,
  output logic      [NUM_PERIPH-1:0]               periph_request,
  output logic      [NUM_PERIPH-1:0]               transfer_start
);

  localparam int N = irq_source_pkg::NUM_EXT;

  // registers
  logic [7:0]           system_control_reg_ff;
  logic [15:0]          sense_control_reg_ff;
  logic [N-1:0]         request_enable_reg_ff;
  logic [N-1:0]         request_flag_reg_ff;
  logic [N-1:0]         flag_read_one_ff;
  logic [7:0]           control_level_reg_ff;
  logic [15:0]          key_mask_bits_ff;
  logic [7:0]           wakeup_mask_bits_ff;

  // synchronisers, edge history and nmi pending
  logic                 nmi_s1_ff;
  logic                 nmi_s2_ff;
  logic                 nmi_prev_ff;
  logic [N-1:0]         ext_s1_ff;
  logic [N-1:0]         ext_s2_ff;
  logic [15:0]          key_s1_ff;
  logic [15:0]          key_s2_ff;
  logic [7:0]           wake_s1_ff;
  logic [7:0]           wake_s2_ff;
  logic [N-1:0]         line_prev_ff;
  logic                 nmi_pending_ff;

  logic [N-1:0]         line_low;
  logic [N-1:0]         trigger;
  logic                 nmi_event;
  logic [N-1:0]         level_of;
  logic [N-1:0]         pending;
  logic [N-1:0]         nxt_flag;
  logic                 any_wake_mask_clear;
  irq_source_pkg::cpu_request_t nxt_request;

  function automatic logic [7:0] ext_vector(input int idx);
    ext_vector = irq_source_pkg::VEC_EXT_BASE + idx[7:0]; // R4 R19
  endfunction

  function automatic logic [irq_source_pkg::VADDR_W-1:0] vec_addr(
    input logic [7:0] vec,
    input logic       adv
  );
    vec_addr = adv ? {14'h0000, vec, 2'h0}            // R20
                   : {15'h0000, vec, 1'h0};           // R20
  endfunction

  function automatic irq_source_pkg::sense_t sense_of(input int idx);
    sense_of = irq_source_pkg::sense_t'(sense_control_reg_ff[2*idx +: 2]);
  endfunction

  // pin synchronisers
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      nmi_s1_ff  <= 1'b1;
      nmi_s2_ff  <= 1'b1;
      ext_s1_ff  <= '1;
      ext_s2_ff  <= '1;
      key_s1_ff  <= '1;
      key_s2_ff  <= '1;
      wake_s1_ff <= '1;
      wake_s2_ff <= '1;
    end
    else
    begin
      // pins sampled regardless of port direction
      nmi_s1_ff  <= nonmask_pin;
      nmi_s2_ff  <= nmi_s1_ff;
      ext_s1_ff  <= external_request_pins;              // R7
      ext_s2_ff  <= ext_s1_ff;
      key_s1_ff  <= key_sense_inputs;
      key_s2_ff  <= key_s1_ff;
      wake_s1_ff <= wakeup_event_inputs;
      wake_s2_ff <= wake_s1_ff;
    end
  end

  // request lines with key and wakeup folding, active high = pin low
  always_comb
  begin
    any_wake_mask_clear = ~(&key_mask_bits_ff[15:8]) | ~(&wakeup_mask_bits_ff); // R9
    line_low = ~ext_s2_ff;
    line_low[7] = (~ext_s2_ff[7] & ~any_wake_mask_clear)                          // R9
                | (|(~key_s2_ff[15:8] & ~key_mask_bits_ff[15:8]))                 // R8 R11
                | (|(~wake_s2_ff & ~wakeup_mask_bits_ff));                        // R8 R11
    line_low[6] = (~ext_s2_ff[6] & ~key_mask_bits_ff[irq_source_pkg::KEY_MASK6_BIT]) // R10
                | (|(~key_s2_ff[7:0] & ~key_mask_bits_ff[7:0]));                  // R8 R11
  end

  // shared sense, flag and level for folded sources
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      case (sense_of(i))                                  // R3 R12
        irq_source_pkg::SENSE_LOW:  trigger[i] = line_low[i];
        irq_source_pkg::SENSE_FALL: trigger[i] = line_low[i] & ~line_prev_ff[i];
        irq_source_pkg::SENSE_RISE: trigger[i] = ~line_low[i] & line_prev_ff[i];
        irq_source_pkg::SENSE_BOTH: trigger[i] = line_low[i] ^ line_prev_ff[i];
        default:                    trigger[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      line_prev_ff <= '0;
      nmi_prev_ff  <= 1'b1;
    end
    else
    begin
      line_prev_ff <= line_low;
      nmi_prev_ff  <= nmi_s2_ff;
    end
  end

  // nmi edge choice
  assign nmi_event = system_control_reg_ff[irq_source_pkg::SYS_NMI_EDGE_BIT]
                   ? (nmi_s2_ff & ~nmi_prev_ff)              // R2
                   : (~nmi_s2_ff & nmi_prev_ff);             // R2

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      nmi_pending_ff <= 1'b0;
    else if (nmi_event)
      nmi_pending_ff <= 1'b1;                                 // R1
    else if (handling_start && handling_vector == irq_source_pkg::VEC_NMI)
      nmi_pending_ff <= 1'b0;
  end

  // status flags: set beats every clear
  always_comb
  begin
    nxt_flag = request_flag_reg_ff;
    for (int i = 0; i < N; i++)
    begin
      if (reg_write && reg_addr == irq_source_pkg::OFS_FLAG
          && !reg_wdata[i] && flag_read_one_ff[i])
        nxt_flag[i] = 1'b0;                                   // R22 R23
      if (handling_start && handling_vector == ext_vector(i)
          && (sense_of(i) != irq_source_pkg::SENSE_LOW || !line_low[i]))
        nxt_flag[i] = 1'b0;                                   // R24
      if (trigger[i])
        nxt_flag[i] = 1'b1;                                   // R6
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      request_flag_reg_ff <= '0;
    else
      request_flag_reg_ff <= nxt_flag;
  end

  // a read that sees 1 arms the clear; a clearing write disarms
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      flag_read_one_ff <= '0;
    else if (reg_read && reg_addr == irq_source_pkg::OFS_FLAG)
      flag_read_one_ff <= flag_read_one_ff | request_flag_reg_ff;  // R23
    else if (reg_write && reg_addr == irq_source_pkg::OFS_FLAG)
      flag_read_one_ff <= flag_read_one_ff & reg_wdata;
  end

  // software registers
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      system_control_reg_ff <= irq_source_pkg::RST_SYSCTL;
      sense_control_reg_ff  <= irq_source_pkg::RST_SENSE;
      request_enable_reg_ff <= irq_source_pkg::RST_ENABLE;        // R25
      control_level_reg_ff  <= irq_source_pkg::RST_LEVEL;
      key_mask_bits_ff      <= irq_source_pkg::RST_KEYMASK;
      wakeup_mask_bits_ff   <= irq_source_pkg::RST_WAKEMASK;
    end
    else if (reg_write)
    begin
      case (reg_addr)
        irq_source_pkg::OFS_SYSCTL:     system_control_reg_ff      <= reg_wdata;
        irq_source_pkg::OFS_SENSE_HI:   sense_control_reg_ff[15:8] <= reg_wdata;
        irq_source_pkg::OFS_SENSE_LO:   sense_control_reg_ff[7:0]  <= reg_wdata;
        irq_source_pkg::OFS_ENABLE:     request_enable_reg_ff      <= reg_wdata;
        irq_source_pkg::OFS_LEVEL:      control_level_reg_ff       <= reg_wdata;
        irq_source_pkg::OFS_KEYMASK_HI: key_mask_bits_ff[15:8]     <= reg_wdata;
        irq_source_pkg::OFS_KEYMASK_LO: key_mask_bits_ff[7:0]      <= reg_wdata;
        irq_source_pkg::OFS_WAKEMASK:   wakeup_mask_bits_ff        <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= '0;
    else if (reg_read)
    begin
      case (reg_addr)
        irq_source_pkg::OFS_SYSCTL:     reg_rdata <= system_control_reg_ff;
        irq_source_pkg::OFS_SENSE_HI:   reg_rdata <= sense_control_reg_ff[15:8];
        irq_source_pkg::OFS_SENSE_LO:   reg_rdata <= sense_control_reg_ff[7:0];
        irq_source_pkg::OFS_ENABLE:     reg_rdata <= request_enable_reg_ff;
        irq_source_pkg::OFS_FLAG:       reg_rdata <= request_flag_reg_ff;
        irq_source_pkg::OFS_LEVEL:      reg_rdata <= control_level_reg_ff;
        irq_source_pkg::OFS_KEYMASK_HI: reg_rdata <= key_mask_bits_ff[15:8];
        irq_source_pkg::OFS_KEYMASK_LO: reg_rdata <= key_mask_bits_ff[7:0];
        irq_source_pkg::OFS_WAKEMASK:   reg_rdata <= wakeup_mask_bits_ff;
        irq_source_pkg::OFS_STATUS:     reg_rdata <= {7'h00, nmi_pending_ff};
        default:                        reg_rdata <= '0;
      endcase
    end
    else
      reg_rdata <= '0;
  end

  // control level per request
  always_comb
  begin
    level_of[0] = control_level_reg_ff[irq_source_pkg::LVL_REQ0_BIT];    // R21
    level_of[1] = control_level_reg_ff[irq_source_pkg::LVL_REQ1_BIT];    // R21
    level_of[2] = control_level_reg_ff[irq_source_pkg::LVL_REQ2_3_BIT];  // R21
    level_of[3] = control_level_reg_ff[irq_source_pkg::LVL_REQ2_3_BIT];
    level_of[4] = control_level_reg_ff[irq_source_pkg::LVL_REQ4_5_BIT];  // R21
    level_of[5] = control_level_reg_ff[irq_source_pkg::LVL_REQ4_5_BIT];
    level_of[6] = control_level_reg_ff[irq_source_pkg::LVL_REQ6_7_BIT];  // R21
    level_of[7] = control_level_reg_ff[irq_source_pkg::LVL_REQ6_7_BIT];
  end

  // cpu masking: mode 0 masks all, mode 1 masks level 0 then all
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      pending[i] = request_flag_reg_ff[i] & request_enable_reg_ff[i];   // R5
      if (cpu_state.int_mask)
      begin
        if (!cpu_state.ctrl_mode1 || cpu_state.user_mask || !level_of[i])
          pending[i] = 1'b0;
      end
    end
  end

  // arbitration: nmi, then level 1 by vector, then level 0 by vector
  always_comb
  begin
    nxt_request = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (pending[i] && !level_of[i])
      begin
        nxt_request.valid  = 1'b1;                                      // R26
        nxt_request.vector = ext_vector(i);                             // R17
      end
    end
    for (int i = N - 1; i >= 0; i--)
    begin
      if (pending[i] && level_of[i])
      begin
        nxt_request.valid  = 1'b1;                                      // R18
        nxt_request.vector = ext_vector(i);                             // R17
      end
    end
    if (nmi_pending_ff)
    begin
      nxt_request.valid  = 1'b1;                                        // R1
      nxt_request.nmi    = 1'b1;
      nxt_request.vector = irq_source_pkg::VEC_NMI;                     // R19
    end
    nxt_request.vaddr = vec_addr(nxt_request.vector, cpu_state.advanced); // R20
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      cpu_request <= '0;
    else
      cpu_request <= nxt_request;
  end

  // standby exit, masks of the cpu do not apply
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      wake_request <= 1'b0;
    else
      wake_request <= standby & (nmi_pending_ff                         // R14
                    | (|(request_flag_reg_ff & request_enable_reg_ff
                         & irq_source_pkg::WAKE_CAPABLE)));             // R14
  end

  // peripheral gating and transfer controller start
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      periph_request <= '0;
      transfer_start <= '0;
    end
    else
    begin
      periph_request <= periph_flag & periph_enable & ~periph_to_transfer; // R15
      transfer_start <= periph_flag & periph_enable & periph_to_transfer;  // R15 R16
    end
  end

endmodule // ext_irq_source
`default_nettype wire

// ==== sim/ext_irq_source_monitor.sv ====
// assertion checker for the external interrupt source logic
`default_nettype none
module ext_irq_source_monitor #(
  parameter int NUM_PERIPH = 4
) (
  input wire logic                              core_clk,
  input wire logic                              rstn,
  input wire logic                              reg_read,
  input wire logic [irq_source_pkg::DATA_W-1:0] reg_rdata,
  input wire irq_source_pkg::cpu_state_t        cpu_state,
  input wire logic                              standby,
  input wire irq_source_pkg::cpu_request_t      cpu_request,
  input wire logic                              wake_request,
  input wire logic [NUM_PERIPH-1:0]             periph_flag,
  input wire logic [NUM_PERIPH-1:0]             periph_enable,
  input wire logic [NUM_PERIPH-1:0]             periph_to_transfer,
  input wire logic [NUM_PERIPH-1:0]             periph_request,
  input wire logic [NUM_PERIPH-1:0]             transfer_start
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]            up_ff;
  logic                  masked;
  logic                  adv;
  logic [NUM_PERIPH-1:0] req_cause;
  logic [NUM_PERIPH-1:0] xfer_cause;

  assign masked     = cpu_state.int_mask && (!cpu_state.ctrl_mode1 || cpu_state.user_mask);
  assign adv        = cpu_state.advanced;
  assign req_cause  = periph_flag & periph_enable & ~periph_to_transfer;
  assign xfer_cause = periph_flag & periph_enable & periph_to_transfer;

  // outputs are held low on the first edge after release; checks skip the first two edges
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
      up_ff <= 2'h0;
    else
      up_ff <= {up_ff[0], 1'b1};

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  chk_nmi_vector: assert property (
    cpu_request.valid && cpu_request.nmi |-> cpu_request.vector == 8'h07)
    else $error("nmi request carries a wrong vector");
  chk_ext_vector_range: assert property (
    cpu_request.valid && !cpu_request.nmi |-> cpu_request.vector inside {[8'h10:8'h17]})
    else $error("external request vector out of range");
  chk_vaddr_scale: assert property (
    up_ff[1] && cpu_request.valid |-> cpu_request.vaddr == ($past(adv) ?
      {14'h0, cpu_request.vector, 2'h0} : {15'h0, cpu_request.vector, 1'h0}))
    else $error("vector address not scaled from vector");
  chk_masked_nmi_only: assert property (
    up_ff[1] && $past(masked) && cpu_request.valid |-> cpu_request.nmi)
    else $error("maskable request passed while cpu masked");
  chk_periph_gate: assert property (
    up_ff[1] |-> periph_request == $past(req_cause))
    else $error("peripheral request not flag and enable");
  chk_transfer_free: assert property (
    up_ff[1] |-> transfer_start == $past(xfer_cause))
    else $error("transfer start wrong");
  chk_wake_standby: assert property (
    wake_request |-> $past(standby))
    else $error("wake request outside standby");
  chk_rdata_idle: assert property (
    up_ff[1] && !$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");

  cover property (cpu_request.valid && cpu_request.nmi);
  cover property (cpu_request.valid && !cpu_request.nmi);
  cover property (wake_request);
  cover property (|transfer_start);
endmodule // ext_irq_source_monitor

bind ext_irq_source ext_irq_source_monitor #(.NUM_PERIPH(NUM_PERIPH)) u_monitor (
  .core_clk, .rstn, .reg_read, .reg_rdata, .cpu_state, .standby, .cpu_request,
  .wake_request, .periph_flag, .periph_enable, .periph_to_transfer,
  .periph_request, .transfer_start
);
`default_nettype wire

// ==== sim/cpu_model.sv ====
// behavioural cpu core that takes presented requests and starts handling
`default_nettype none
module cpu_model (
  input  wire logic                         core_clk,
  input  wire logic                         rstn,
  input  wire irq_source_pkg::cpu_request_t cpu_request,
  input  wire logic                         accept_en,
  input  wire logic                         slow,
  output logic                              handling_start,
  output logic [irq_source_pkg::VEC_W-1:0]  handling_vector
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_ff;
  logic [2:0] hold_ff;

  // request lags the start by two edges, so sit out a few cycles after each
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      handling_start  <= 1'b0;
      handling_vector <= 8'h00;
      wait_ff         <= 3'h0;
      hold_ff         <= 3'h0;
    end
    else
    begin
      handling_start <= 1'b0;
      if (hold_ff != 3'h0)
        hold_ff <= hold_ff - 3'h1;
      else if (accept_en && cpu_request.valid)
      begin
        if (slow && wait_ff != 3'h3)
          wait_ff <= wait_ff + 3'h1;
        else
        begin
          handling_start  <= 1'b1;
          handling_vector <= cpu_request.vector;
          wait_ff         <= 3'h0;
          hold_ff         <= 3'h4;
        end
      end
    end
  end
endmodule // cpu_model
`default_nettype wire

// ==== sim/ext_irq_source_tb.sv ====
// self-checking bench for the external interrupt source logic
`default_nettype none
module ext_irq_source_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk, rstn, reg_write, reg_read, nonmask_pin, standby, accept_en, slow;
  logic        hs, wake;
  logic [3:0]  reg_addr, cst, pf, pe, pt, preq, ts;
  logic [7:0]  reg_wdata, reg_rdata, d, ext_pins, wake_in, hv;
  logic [15:0] keys;
  irq_source_pkg::cpu_request_t creq;
  int          n_errors, compares;
  localparam logic [3:0] EXP_A = 4'hB;
  localparam logic [3:0] EXP_B = 4'hD;
  localparam logic [7:0] RST_TAB [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                          8'hFF, 8'hBF, 8'hFF, 8'h00, 8'h00};

  ext_irq_source #(.NUM_PERIPH(4)) dut (
    .core_clk, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .nonmask_pin, .external_request_pins(ext_pins), .key_sense_inputs(keys),
    .wakeup_event_inputs(wake_in), .cpu_state(cst), .handling_start(hs),
    .handling_vector(hv), .standby, .cpu_request(creq), .wake_request(wake),
    .periph_flag(pf), .periph_enable(pe), .periph_to_transfer(pt),
    .periph_request(preq), .transfer_start(ts)
  );

  cpu_model cpu (
    .core_clk, .rstn, .cpu_request(creq), .accept_en, .slow,
    .handling_start(hs), .handling_vector(hv)
  );

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
    chk({16'h0, d}, {16'h0, e});
  endtask

  // read arms the set bits, the write of zero then clears them
  task automatic clr();
    @(posedge core_clk);
    reg_addr <= irq_source_pkg::OFS_FLAG;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    wr(irq_source_pkg::OFS_FLAG, 8'h00);
  endtask

  task automatic rq(input logic v, input logic [7:0] vec, input logic [23:0] va);
    chk(24'(creq.valid), 24'(v));
    if (v)
    begin
      chk(24'(creq.vector), 24'(vec));
      chk(creq.vaddr, va);
    end
  endtask

  task automatic pchk(input logic [3:0] f, input logic [3:0] e, input logic [3:0] t);
    @(posedge core_clk);
    pf <= f;
    pe <= e;
    pt <= t;
    cyc(2);
    chk(24'(preq), 24'(f & e & ~t));
    chk(24'(ts), 24'(f & e & t));
  endtask

  task automatic pins(input logic [7:0] v);
    @(posedge core_clk);
    ext_pins <= v;
    cyc(6);
  endtask

  task automatic final_report;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    final_report;
  end

  initial
  begin
    {rstn, reg_write, reg_read, standby, accept_en, slow} = 6'h00;
    {reg_addr, cst, pf, pe, pt, reg_wdata} = 28'h0;
    {nonmask_pin, ext_pins, wake_in, keys} = 33'h1FFFFFFFF;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 11; i++)
      rchk(4'(i), RST_TAB[i]);
    wr(irq_source_pkg::OFS_ENABLE, 8'hA5);
    rchk(irq_source_pkg::OFS_ENABLE, 8'hA5);
    wr(4'hA, 8'h5A);
    rchk(4'hA, 8'h00);
    wr(irq_source_pkg::OFS_ENABLE, 8'h00);
    // each sense code: flag after the fall, then after a clear and the rise
    for (int m = 0; m < 4; m++)
    begin
      wr(irq_source_pkg::OFS_SENSE_LO, {6'h0, 2'(m)});
      clr();
      pins(8'hFE);
      rchk(irq_source_pkg::OFS_FLAG, {7'h0, EXP_A[m]});
      clr();
      pins(8'hFF);
      rchk(irq_source_pkg::OFS_FLAG, {7'h0, EXP_B[m]});
    end
    chk(24'(creq.valid), 24'h0);
    wr(irq_source_pkg::OFS_FLAG, 8'hFF);
    rchk(irq_source_pkg::OFS_FLAG, 8'h01);
    wr(irq_source_pkg::OFS_FLAG, 8'h00);
    rchk(irq_source_pkg::OFS_FLAG, 8'h00);
    pins(8'hFE);
    wr(irq_source_pkg::OFS_FLAG, 8'h00);
    rchk(irq_source_pkg::OFS_FLAG, 8'h01);
    wr(irq_source_pkg::OFS_SENSE_HI, 8'h55);
    wr(irq_source_pkg::OFS_SENSE_LO, 8'h55);
    pins(8'hFF);
    clr();
    wr(irq_source_pkg::OFS_ENABLE, 8'hFF);
    pins(8'hDB);
    rq(1'b1, 8'h12, 24'h24);
    wr(irq_source_pkg::OFS_LEVEL, 8'h10);
    cyc(3);
    rq(1'b1, 8'h15, 24'h2A);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge core_clk);
      cst <= 4'(16'hEC41 >> (4 * k));
      cyc(3);
      rq(k[0] ? 1'b0 : 1'b1, 8'h15, k == 0 ? 24'h54 : 24'h2A);
    end
    @(posedge core_clk);
    cst       <= 4'h0;
    accept_en <= 1'b1;
    slow      <= 1'b1;
    pins(8'hFF);
    cyc(30);
    rq(1'b0, 8'h00, 24'h0);
    rchk(irq_source_pkg::OFS_FLAG, 8'h00);
    wr(irq_source_pkg::OFS_ENABLE, 8'h00);
    @(posedge core_clk);
    accept_en   <= 1'b0;
    slow        <= 1'b0;
    cst         <= 4'h4;
    nonmask_pin <= 1'b0;
    cyc(6);
    chk(24'(creq.nmi), 24'h1);
    rq(1'b1, 8'h07, 24'h0E);
    rchk(irq_source_pkg::OFS_STATUS, 8'h01);
    wr(irq_source_pkg::OFS_SYSCTL, 8'h08);
    @(posedge core_clk);
    accept_en <= 1'b1;
    cyc(10);
    rq(1'b0, 8'h00, 24'h0);
    @(posedge core_clk);
    accept_en   <= 1'b0;
    nonmask_pin <= 1'b1;
    cyc(6);
    rq(1'b1, 8'h07, 24'h0E);
    @(posedge core_clk);
    accept_en <= 1'b1;
    cyc(10);
    accept_en <= 1'b0;
    clr();
    pins(8'h7F);
    rchk(irq_source_pkg::OFS_FLAG, 8'h80);
    pins(8'hFF);
    clr();
    wr(irq_source_pkg::OFS_KEYMASK_HI, 8'hFE);
    pins(8'h7F);
    rchk(irq_source_pkg::OFS_FLAG, 8'h00);
    @(posedge core_clk);
    keys <= 16'hFEFF;
    cyc(6);
    rchk(irq_source_pkg::OFS_FLAG, 8'h80);
    @(posedge core_clk);
    keys <= 16'hFFFF;
    pins(8'hFF);
    wr(irq_source_pkg::OFS_KEYMASK_HI, 8'hFF);
    wr(irq_source_pkg::OFS_WAKEMASK, 8'hF7);
    clr();
    @(posedge core_clk);
    wake_in <= 8'hF7;
    cyc(6);
    rchk(irq_source_pkg::OFS_FLAG, 8'h80);
    wr(irq_source_pkg::OFS_KEYMASK_LO, 8'hBE);
    clr();
    @(posedge core_clk);
    keys <= 16'hFFFD;
    cyc(6);
    rchk(irq_source_pkg::OFS_FLAG, 8'h00);
    @(posedge core_clk);
    keys <= 16'hFFFC;
    cyc(6);
    rchk(irq_source_pkg::OFS_FLAG, 8'h40);
    @(posedge core_clk);
    keys    <= 16'hFFFF;
    wake_in <= 8'hFF;
    standby <= 1'b1;
    wr(irq_source_pkg::OFS_ENABLE, 8'hFF);
    clr();
    pins(8'hF7);
    chk(24'(wake), 24'h0);
    pins(8'hF3);
    chk(24'(wake), 24'h1);
    pchk(4'hF, 4'h6, 4'hC);
    pchk(4'h9, 4'hF, 4'h1);
    final_report;
  end
endmodule // ext_irq_source_tb
`default_nettype wire
